// ---- hdl/tsrb_map.svh ----
// register map constants for the temperature sensor register bank
// assumes a serial protocol engine outside hands over decoded byte events
`ifndef TSRB_MAP_SVH
`define TSRB_MAP_SVH
`define TSRB_SEL_TEMP      2'h0
`define TSRB_SEL_CFG       2'h1
`define TSRB_SEL_LOW       2'h2
`define TSRB_SEL_HIGH      2'h3
`define TSRB_PTR_RST       8'h00
`define TSRB_TEMP_RST      16'h0000
`define TSRB_CFG_RST       16'h00FF
`define TSRB_LOW_RST       16'h4B00
`define TSRB_HIGH_RST      16'h5000
`define TSRB_CFG_LOW_BYTE  8'hFF
`define TSRB_RES_NIBBLE    4'h0
`define TSRB_OS_BIT        15
`define TSRB_POL_BIT       10
`define TSRB_TM_BIT        9
`define TSRB_SD_BIT        8
`define TSRB_RATE_HI       14
`define TSRB_RATE_LO       13
`define TSRB_FQ_HI         12
`define TSRB_FQ_LO         11
`endif

// ---- hdl/tsrb_pkg.sv ----
// types shared by the temperature sensor register bank
// assumes tsrb_map.svh supplies the register map constants; the write state encodings are set here
package tsrb_pkg;
  typedef struct packed {
    logic       os;
    logic [1:0] rate;
    logic [1:0] fq;
    logic       alert_polarity;
    logic       tm;
    logic       sd;
  } tsrb_cfg_t;

  typedef enum logic [1:0] {
    TSRB_IDLE  = 2'b00,
    TSRB_BYTE2 = 2'b01
  } tsrb_wr_state_t;
endpackage

// ---- hdl/tsrb_bank.sv ----
// register bank of a digital temperature sensor
// assumes the serial engine delivers one-cycle byte strobes synchronous to clk_sys_i
`timescale 1ns/100ps
`include "tsrb_map.svh"
module tsrb_bank (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ptr_wr_i,
  input  wire logic [7:0]  ptr_data_i,
  input  wire logic        byte_wr_i,
  input  wire logic [7:0]  byte_data_i,
  input  wire logic        xfer_end_i,
  input  wire logic        conv_done_i,
  input  wire logic [11:0] conv_result_i,
  output logic [15:0]      rd_data_o,
  output tsrb_pkg::tsrb_cfg_t cfg_o,
  output logic             oneshot_start_o,
  output logic             alert_clear_o,
  output logic             above_high_o,
  output logic             below_low_o,
  output logic             shutdown_o
);
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  logic [7:0]  ptr_reg;
  logic [15:0] temp_reg;
  tsrb_pkg::tsrb_cfg_t cfg_reg;
  logic [11:0] low_reg;
  logic [11:0] high_reg;
  logic        oneshot_reg;
  logic        sd_prev_reg;
  tsrb_pkg::tsrb_wr_state_t wr_state_reg;
  logic        commit_word;
  logic        commit_upper;
  logic [15:0] wr_word;

  function automatic logic [15:0] read_mux(input logic [1:0] sel, input logic [15:0] t,
                                           input tsrb_pkg::tsrb_cfg_t c,
                                           input logic [11:0] lo, input logic [11:0] hi);
    case (sel)
      `TSRB_SEL_TEMP: read_mux = t;
      `TSRB_SEL_CFG:  read_mux = {1'b0, c.rate, c.fq, c.alert_polarity, c.tm, c.sd, `TSRB_CFG_LOW_BYTE};
      `TSRB_SEL_LOW:  read_mux = {lo, `TSRB_RES_NIBBLE};
      `TSRB_SEL_HIGH: read_mux = {hi, `TSRB_RES_NIBBLE};
      default:        read_mux = `TSRB_TEMP_RST;
    endcase
  endfunction

  // ----------------------------------------------------------
  // pointer
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_reg <= `TSRB_PTR_RST;
    end else if (ptr_wr_i) begin
      ptr_reg <= ptr_data_i;
    end
  end

  // ----------------------------------------------------------
  // byte pairing, msb first
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_state_reg <= tsrb_pkg::TSRB_IDLE;
    end else begin
      case (wr_state_reg)
        tsrb_pkg::TSRB_IDLE: begin
          if (ptr_wr_i) begin
            wr_state_reg <= tsrb_pkg::TSRB_BYTE2;
          end
        end
        tsrb_pkg::TSRB_BYTE2: begin
          if (xfer_end_i) begin
            wr_state_reg <= tsrb_pkg::TSRB_IDLE;
          end
        end
        default: wr_state_reg <= tsrb_pkg::TSRB_IDLE;
      endcase
    end
  end

  // a counter of bytes is cleaner than a zero test of the held byte
  logic [1:0] byte_cnt_reg;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      byte_cnt_reg <= 2'h0;
    end else if (xfer_end_i || ptr_wr_i) begin
      byte_cnt_reg <= 2'h0;
    end else if (byte_wr_i && wr_state_reg == tsrb_pkg::TSRB_BYTE2 && byte_cnt_reg != 2'h2) begin
      byte_cnt_reg <= byte_cnt_reg + 2'h1;
    end
  end

  logic [7:0] upper_reg;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      upper_reg <= 8'h00;
    end else if (byte_wr_i && byte_cnt_reg == 2'h0) begin
      upper_reg <= byte_data_i;
    end
  end

  // second byte completes the word; an end after one byte commits upper only
  assign commit_word  = byte_wr_i && byte_cnt_reg == 2'h1 && wr_state_reg == tsrb_pkg::TSRB_BYTE2;
  assign commit_upper = xfer_end_i && byte_cnt_reg == 2'h1;
  assign wr_word      = {upper_reg, byte_data_i};

  // ----------------------------------------------------------
  // configuration and limits
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg  <= tsrb_pkg::tsrb_cfg_t'(8'(`TSRB_CFG_RST >> 8));
      low_reg  <= 12'(`TSRB_LOW_RST >> 4);
      high_reg <= 12'(`TSRB_HIGH_RST >> 4);
    end else if (commit_word || commit_upper) begin
      case (ptr_reg[1:0])
        `TSRB_SEL_CFG: begin
          cfg_reg.rate <= upper_reg[`TSRB_RATE_HI-8:`TSRB_RATE_LO-8];
          cfg_reg.fq   <= upper_reg[`TSRB_FQ_HI-8:`TSRB_FQ_LO-8];
          cfg_reg.alert_polarity  <= upper_reg[`TSRB_POL_BIT-8];
          cfg_reg.tm   <= upper_reg[`TSRB_TM_BIT-8];
          cfg_reg.sd   <= upper_reg[`TSRB_SD_BIT-8];
          cfg_reg.os   <= 1'b0;
        end
        `TSRB_SEL_LOW: begin
          if (commit_word) low_reg <= wr_word[15:4];
          else low_reg[11:4] <= upper_reg;
        end
        `TSRB_SEL_HIGH: begin
          if (commit_word) high_reg <= wr_word[15:4];
          else high_reg[11:4] <= upper_reg;
        end
        default: cfg_reg.os <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------
  // one-shot and shutdown edge
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      oneshot_reg <= 1'b0;
    end else if ((commit_word || commit_upper) && ptr_reg[1:0] == `TSRB_SEL_CFG
                 && upper_reg[`TSRB_OS_BIT-8] && cfg_reg.sd) begin
      oneshot_reg <= 1'b1;
    end else if (conv_done_i) begin
      oneshot_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sd_prev_reg <= 1'b0;
    end else begin
      sd_prev_reg <= cfg_reg.sd;
    end
  end

  // ----------------------------------------------------------
  // temperature result and comparisons
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      temp_reg <= `TSRB_TEMP_RST;
    end else if (conv_done_i && (!cfg_reg.sd || oneshot_reg)) begin
      temp_reg <= {conv_result_i, `TSRB_RES_NIBBLE};
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o       <= `TSRB_TEMP_RST;
      cfg_o           <= tsrb_pkg::tsrb_cfg_t'(8'(`TSRB_CFG_RST >> 8));
      oneshot_start_o <= 1'b0;
      alert_clear_o   <= 1'b0;
      above_high_o    <= 1'b0;
      below_low_o     <= 1'b0;
      shutdown_o      <= 1'b0;
    end else begin
      rd_data_o       <= read_mux(ptr_reg[1:0], temp_reg, cfg_reg, low_reg, high_reg);
      cfg_o           <= cfg_reg;
      oneshot_start_o <= oneshot_reg;
      alert_clear_o   <= cfg_reg.sd && !sd_prev_reg;
      // signed compare keeps negative temperatures ordered correctly
      above_high_o    <= $signed(temp_reg[15:4]) >= $signed(high_reg);
      below_low_o     <= $signed(temp_reg[15:4]) <  $signed(low_reg);
      shutdown_o      <= cfg_reg.sd && !oneshot_reg;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  property p_ptr_load;
    @(posedge clk_sys_i) disable iff (rst_i) ptr_wr_i |=> ptr_reg == $past(ptr_data_i);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_cfg_read;
    @(posedge clk_sys_i) disable iff (rst_i)
      ptr_reg[1:0] == `TSRB_SEL_CFG && !ptr_wr_i |=> rd_data_o[7:0] == `TSRB_CFG_LOW_BYTE && !rd_data_o[15];
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

  property p_temp_nibble;
    @(posedge clk_sys_i) disable iff (rst_i) temp_reg[3:0] == `TSRB_RES_NIBBLE;
  endproperty
  a_temp_nibble: assert property (p_temp_nibble) else $error("reserved nibble set");

  property p_conv;
    @(posedge clk_sys_i) disable iff (rst_i)
      conv_done_i && !cfg_reg.sd |=> temp_reg[15:4] == $past(conv_result_i);
  endproperty
  a_conv: assert property (p_conv) else $error("result not stored");

  property p_sd_edge;
    @(posedge clk_sys_i) disable iff (rst_i) $rose(cfg_reg.sd) |=> alert_clear_o ##1 !alert_clear_o;
  endproperty
  a_sd_edge: assert property (p_sd_edge) else $error("clear pulse wrong");

  property p_oneshot_end;
    @(posedge clk_sys_i) disable iff (rst_i) oneshot_reg && conv_done_i |=> !oneshot_reg;
  endproperty
  a_oneshot_end: assert property (p_oneshot_end) else $error("one-shot stuck");

  property p_upper_only;
    @(posedge clk_sys_i) disable iff (rst_i)
      commit_upper && ptr_reg[1:0] == `TSRB_SEL_HIGH |=> high_reg[3:0] == $past(high_reg[3:0]);
  endproperty
  a_upper_only: assert property (p_upper_only) else $error("lower byte touched");

  property p_cmp;
    @(posedge clk_sys_i) disable iff (rst_i)
      $signed(temp_reg[15:4]) < $signed(low_reg) |=> below_low_o;
  endproperty
  a_cmp: assert property (p_cmp) else $error("low compare wrong");

  property p_rd_temp;
    @(posedge clk_sys_i) disable iff (rst_i)
      ptr_reg[1:0] == `TSRB_SEL_TEMP |=> rd_data_o == $past(temp_reg);
  endproperty
  a_rd_temp: assert property (p_rd_temp) else $error("temperature read wrong");

  property p_rd_low;
    @(posedge clk_sys_i) disable iff (rst_i)
      ptr_reg[1:0] == `TSRB_SEL_LOW |=> rd_data_o == {$past(low_reg), `TSRB_RES_NIBBLE};
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("low limit read wrong");

  property p_rd_high;
    @(posedge clk_sys_i) disable iff (rst_i)
      ptr_reg[1:0] == `TSRB_SEL_HIGH |=> rd_data_o == {$past(high_reg), `TSRB_RES_NIBBLE};
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("high limit read wrong");

  property p_rd_cfg;
    @(posedge clk_sys_i) disable iff (rst_i)
      ptr_reg[1:0] == `TSRB_SEL_CFG |=> rd_data_o[`TSRB_RATE_HI:`TSRB_SD_BIT]
        == $past({cfg_reg.rate, cfg_reg.fq, cfg_reg.alert_polarity, cfg_reg.tm, cfg_reg.sd});
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config fields read wrong");

  property p_ptr_hold;
    @(posedge clk_sys_i) disable iff (rst_i) !ptr_wr_i |=> $stable(ptr_reg);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");

  property p_temp_ro;
    @(posedge clk_sys_i) disable iff (rst_i) !conv_done_i |=> $stable(temp_reg);
  endproperty
  a_temp_ro: assert property (p_temp_ro) else $error("temperature written");

  property p_os_zero;
    @(posedge clk_sys_i) disable iff (rst_i) !cfg_reg.os;
  endproperty
  a_os_zero: assert property (p_os_zero) else $error("one-shot bit stored");

  property p_cfg_write;
    @(posedge clk_sys_i) disable iff (rst_i)
      (commit_word || commit_upper) && ptr_reg[1:0] == `TSRB_SEL_CFG
        |=> {cfg_reg.rate, cfg_reg.fq, cfg_reg.alert_polarity, cfg_reg.tm, cfg_reg.sd}
            == $past(upper_reg[`TSRB_RATE_HI-8:`TSRB_SD_BIT-8]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config not stored");

  property p_low_word;
    @(posedge clk_sys_i) disable iff (rst_i)
      commit_word && ptr_reg[1:0] == `TSRB_SEL_LOW |=> low_reg == $past(wr_word[15:4]);
  endproperty
  a_low_word: assert property (p_low_word) else $error("low limit not stored");

  property p_high_word;
    @(posedge clk_sys_i) disable iff (rst_i)
      commit_word && ptr_reg[1:0] == `TSRB_SEL_HIGH |=> high_reg == $past(wr_word[15:4]);
  endproperty
  a_high_word: assert property (p_high_word) else $error("high limit not stored");

  property p_clear_needs_sd;
    @(posedge clk_sys_i) disable iff (rst_i) alert_clear_o |-> $past(cfg_reg.sd);
  endproperty
  a_clear_needs_sd: assert property (p_clear_needs_sd) else $error("clear without shutdown");

  property p_shutdown_out;
    @(posedge clk_sys_i) disable iff (rst_i)
      cfg_reg.sd && !oneshot_reg |=> shutdown_o;
  endproperty
  a_shutdown_out: assert property (p_shutdown_out) else $error("shutdown level wrong");

  property p_above;
    @(posedge clk_sys_i) disable iff (rst_i)
      $signed(temp_reg[15:4]) >= $signed(high_reg) |=> above_high_o;
  endproperty
  a_above: assert property (p_above) else $error("high compare wrong");

  property p_oneshot_store;
    @(posedge clk_sys_i) disable iff (rst_i)
      conv_done_i && oneshot_reg |=> temp_reg == {$past(conv_result_i), `TSRB_RES_NIBBLE};
  endproperty
  a_oneshot_store: assert property (p_oneshot_store) else $error("one-shot result lost");

  property p_byte_cap;
    @(posedge clk_sys_i) disable iff (rst_i) byte_cnt_reg != 2'h3;
  endproperty
  a_byte_cap: assert property (p_byte_cap) else $error("byte count overran");

  property p_oneshot_set;
    @(posedge clk_sys_i) disable iff (rst_i)
      (commit_word || commit_upper) && ptr_reg[1:0] == `TSRB_SEL_CFG
        && upper_reg[`TSRB_OS_BIT-8] && cfg_reg.sd |=> oneshot_reg;
  endproperty
  a_oneshot_set: assert property (p_oneshot_set) else $error("one-shot not started");

  c_oneshot: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(oneshot_reg));
  c_sd_conv: cover property (@(posedge clk_sys_i) disable iff (rst_i) conv_done_i && oneshot_reg);
  c_sd_rise: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(cfg_reg.sd));
  c_word:    cover property (@(posedge clk_sys_i) disable iff (rst_i) commit_word);
  c_upper:   cover property (@(posedge clk_sys_i) disable iff (rst_i) commit_upper);
endmodule

// ---- test/tsrb_host_model.sv ----
// host controller model: pointer writes, register bytes and transfer ends
// assumes a free-running clk_sys_i; it drives on the falling edge only
`timescale 1ns/100ps
module tsrb_host_model (
  input  wire logic       clk_sys_i,
  output logic            ptr_wr_o,
  output logic [7:0]      ptr_data_o,
  output logic            byte_wr_o,
  output logic [7:0]      byte_data_o,
  output logic            xfer_end_o
);
  initial begin
    ptr_wr_o    = 1'b0;
    ptr_data_o  = 8'h00;
    byte_wr_o   = 1'b0;
    byte_data_o = 8'h00;
    xfer_end_o  = 1'b0;
  end
  // -----------------------------------------------
  // byte events
  // -----------------------------------------------
  // released data shows the inverse, so a stale byte never looks live
  task automatic send_ptr(input logic [1:0] sel);
    @(negedge clk_sys_i);
    ptr_wr_o   = 1'b1;
    ptr_data_o = {6'h00, sel};
    @(negedge clk_sys_i);
    ptr_wr_o   = 1'b0;
    ptr_data_o = ~ptr_data_o;
  endtask
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk_sys_i);
    byte_wr_o   = 1'b1;
    byte_data_o = b;
    @(negedge clk_sys_i);
    byte_wr_o   = 1'b0;
    byte_data_o = ~b;
  endtask
  task automatic send_end();
    @(negedge clk_sys_i);
    xfer_end_o = 1'b1;
    @(negedge clk_sys_i);
    xfer_end_o = 1'b0;
  endtask
  // msb first; a one-byte write stops after the upper half
  task automatic write_reg(input logic [1:0] sel, input logic [15:0] w, input int nbytes);
    send_ptr(sel);
    send_byte(w[15:8]);
    if (nbytes == 2) begin
      send_byte(w[7:0]);
    end
    send_end();
  endtask
endmodule

// ---- test/temp_sensor_register_bank_tb.sv ----
// self-checking bench for the temperature sensor register bank
// assumes tsrb_host_model stands in for the serial engine
`timescale 1ns/100ps
module temp_sensor_register_bank_tb;
  logic                clk_sys_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                conv_done_i = 1'b0;
  logic [11:0]         conv_result_i = 12'h000;
  logic                ptr_wr, byte_wr, xfer_end;
  logic [7:0]          ptr_data, byte_data;
  logic [15:0]         rd_data_o, w, lo_w, hi_w;
  tsrb_pkg::tsrb_cfg_t cfg_o;
  logic                oneshot_start_o, alert_clear_o, above_high_o, below_low_o, shutdown_o;
  logic [11:0]         r;
  int                  fail_count = 0;
  int                  checks_done = 0;
  int                  clr_count = 0;

  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (alert_clear_o === 1'b1) clr_count++;

  tsrb_host_model i_host (.clk_sys_i(clk_sys_i), .ptr_wr_o(ptr_wr), .ptr_data_o(ptr_data),
    .byte_wr_o(byte_wr), .byte_data_o(byte_data), .xfer_end_o(xfer_end));
  tsrb_bank i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ptr_wr_i(ptr_wr), .ptr_data_i(ptr_data),
    .byte_wr_i(byte_wr), .byte_data_i(byte_data), .xfer_end_i(xfer_end), .conv_done_i(conv_done_i),
    .conv_result_i(conv_result_i), .rd_data_o(rd_data_o), .cfg_o(cfg_o), .oneshot_start_o(oneshot_start_o),
    .alert_clear_o(alert_clear_o), .above_high_o(above_high_o), .below_low_o(below_low_o),
    .shutdown_o(shutdown_o));
  // -----------------------------------------------
  // helpers
  // -----------------------------------------------
  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic read_chk(input logic [1:0] sel, input logic [15:0] exp);
    i_host.send_ptr(sel);
    i_host.send_end();
    repeat (2) @(negedge clk_sys_i);
    check(rd_data_o, exp);
  endtask
  task automatic conv(input logic [11:0] v);
    @(negedge clk_sys_i);
    conv_done_i   = 1'b1;
    conv_result_i = v;
    @(negedge clk_sys_i);
    conv_done_i   = 1'b0;
    conv_result_i = ~v;
    repeat (2) @(negedge clk_sys_i);
  endtask
  function automatic logic [1:0] cmp_exp(input logic [11:0] t, input logic [15:0] lo, input logic [15:0] hi);
    return {($signed(t) >= $signed(hi[15:4])), ($signed(t) < $signed(lo[15:4]))};
  endfunction
  // -----------------------------------------------
  // sequence
  // -----------------------------------------------
  initial begin
    repeat (50000) @(posedge clk_sys_i);
    fail_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(62));
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    @(negedge clk_sys_i);
    read_chk(2'h0, 16'h0000);
    read_chk(2'h1, 16'h00FF);
    read_chk(2'h2, 16'h4B00);
    read_chk(2'h3, 16'h5000);
    check({8'h00, cfg_o}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom);
      w[14:11] = {i[1:0], i[1:0]};
      w[8] = 1'b0;
      i_host.write_reg(2'h1, w, 2);
      read_chk(2'h1, {1'b0, w[14:8], 8'hFF});
      check({8'h00, cfg_o}, {9'h000, w[14:8]});
    end
    for (int i = 0; i < 6; i++) begin
      lo_w = 16'($urandom);
      hi_w = 16'($urandom);
      r = 12'($urandom);
      if (i == 0) r = hi_w[15:4];
      if (i == 1) r = lo_w[15:4];
      i_host.write_reg(2'h2, lo_w, 2);
      i_host.write_reg(2'h3, hi_w, 2);
      read_chk(2'h2, {lo_w[15:4], 4'h0});
      read_chk(2'h3, {hi_w[15:4], 4'h0});
      conv(r);
      read_chk(2'h0, {r, 4'h0});
      check({14'h0000, above_high_o, below_low_o}, {14'h0000, cmp_exp(r, lo_w, hi_w)});
    end
    i_host.write_reg(2'h0, 16'hFFFF, 2);
    read_chk(2'h0, {r, 4'h0});
    w = 16'($urandom);
    i_host.write_reg(2'h3, w, 1);
    read_chk(2'h3, {w[15:8], hi_w[7:4], 4'h0});
    i_host.write_reg(2'h1, 16'h0100, 2);
    check(clr_count[15:0], 16'h0001);
    check({15'h0000, shutdown_o}, 16'h0001);
    i_host.write_reg(2'h1, 16'h0100, 2);
    check(clr_count[15:0], 16'h0001);
    i_host.write_reg(2'h1, 16'h8100, 2);
    check({14'h0000, oneshot_start_o, shutdown_o}, 16'h0002);
    read_chk(2'h1, 16'h01FF);
    conv(12'h123);
    check({14'h0000, oneshot_start_o, shutdown_o}, 16'h0001);
    read_chk(2'h0, 16'h1230);
    print_verdict();
  end
endmodule
